/* File: pkg/srd_pkg.sv */
`default_nettype none
package srd_pkg;

  // command bytes
  localparam logic [7:0] SRD_CMD_FULL_STATUS = 8'h81;
  localparam logic [7:0] SRD_CMD_POSITIONS   = 8'hfc;
  localparam logic [7:0] SRD_CMD_FUSE_BYTES  = 8'h82;
  localparam logic [7:0] SRD_CMD_MOVE_SAFE   = 8'h84;

  // address byte layout
  localparam logic [1:0] SRD_ADDR_FIXED   = 2'h3;
  localparam logic [6:0] SRD_GENERAL_CALL = 7'h00;
  localparam logic       SRD_RW_READ      = 1'b1;

  // reply framing
  localparam int         SRD_REPLY_BYTES   = 8;
  localparam logic [3:0] SRD_ECHO_FIXED    = 4'hf;
  localparam logic [7:0] SRD_FILLER        = 8'hff;
  localparam logic [4:0] SRD_SAFE_HI_FILL  = 5'h1f;
  localparam logic       SRD_STATUS3_FIXED = 1'b1;
  localparam logic [63:0] SRD_REPLY_RESET  = 64'hffff_ffff_ffff_ffff;

  // half stepping clears the three low position bits
  localparam logic [1:0]  SRD_STEP_HALF      = 2'h0;
  localparam logic [15:0] SRD_HALF_STEP_MASK = 16'hfff8;

  // bit slots within a byte on the wire, and the reply byte index that ends a read
  localparam logic [3:0] SRD_LAST_BIT = 4'h7;
  localparam logic [3:0] SRD_ACK_SLOT = 4'h8;
  localparam logic [3:0] SRD_TX_DONE  = 4'h8;

  // link states, gray along address, command, data
  typedef enum logic [2:0] {
    SRD_LS_ADDR   = 3'h0,
    SRD_LS_CMD    = 3'h1,
    SRD_LS_DATA   = 3'h3,
    SRD_LS_TX     = 3'h2,
    SRD_LS_IGNORE = 3'h6
  } srd_link_state_t;

endpackage
`default_nettype wire

/* File: logic/srd_bus_watch.sv */
`default_nettype none
module srd_bus_watch (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic scl_pin,
  input  wire logic sda_pin,
  output var  logic link_clear
);

  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic sda_s1;
    logic sda_s2;
    logic sda_d;
    logic armed;
    logic clear;
  } srd_watch_t;

  srd_watch_t q;
  srd_watch_t next_q;
  logic       start_seen;
  logic       stop_seen;

  // start and stop are sda edges while scl is high
  assign start_seen = q.scl_s2 & q.sda_d & ~q.sda_s2;
  assign stop_seen  = q.scl_s2 & ~q.sda_d & q.sda_s2;

  // hold the link logic cleared between frames; release once scl falls after a start,
  // well before the first data edge, so the stopped link clock sees a clean release
  always_comb begin
    next_q        = q;
    next_q.scl_s1 = scl_pin;
    next_q.scl_s2 = q.scl_s1;
    next_q.sda_s1 = sda_pin;
    next_q.sda_s2 = q.sda_s1;
    next_q.sda_d  = q.sda_s2;
    if (stop_seen) begin
      next_q.clear = 1'b1;
      next_q.armed = 1'b0;
    end else if (start_seen) begin
      next_q.clear = 1'b1;
      next_q.armed = 1'b1;
    end else if (q.armed && !q.scl_s2) begin
      next_q.clear = 1'b0;
      next_q.armed = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= '{scl_s1: 1'b1, scl_s2: 1'b1, sda_s1: 1'b1, sda_s2: 1'b1, sda_d: 1'b1, armed: 1'b0, clear: 1'b1};
    end else begin
      q <= next_q;
    end
  end

  assign link_clear = q.clear;

endmodule
`default_nettype wire

/* File: logic/srd_status_readback_command_decoder.sv */
// Function
// [R1] command byte 0x81 asks for the full motor and diagnostic status, which the device decodes and prepares.
// [R2] command byte 0xfc asks for actual, target and safe positions, which the device decodes and prepares.
// [R3] command byte 0x82 asks for the fuse bytes, which the device returns.
// [R4] command byte 0x84 orders a move to the safe position, which the device starts on decoding.
// [R5] the master writes address plus status command, then reads the reply in a separate read transfer.
// [R6] full status byte 2 is run current high and hold current low, byte 3 max velocity high and min low.
// [R7] full status byte 4 holds ramp profile, step resolution, direction and ramp rate from bit 7 down.
// [R8] full status byte 5 holds supply reset, missed step, defect, undervoltage, shutdown, warning, temperature.
// [R9] full status byte 6 holds movement state, switch, coil 1 and 2 overcurrent, a one, charge pump fault.
// [R10] positions are 16 bits and read with the three low bits zero in half stepping.
// [R11] position reply bytes 2 and 3 are actual position high then low, bytes 4 and 5 target high then low.
// [R12] the position reply also returns the 16-bit target and the 11-bit safe position.
// [R13] position byte 6 is safe bits 7:0, byte 7 five ones then safe bits 10:8, byte 8 all ones.
// [R14] the fuse reply sends fuse locations 0 to 7 in ascending order as reply bytes 1 to 8.
// [R15] the safe position move is taken at the own address and at the general call address.
// [R16] address byte is two ones, four fuse address bits, the strap bit, then the read/write bit.
// [R17] both status replies echo four ones and the fuse address in byte 1; full status bytes 7 and 8 are all ones.
`default_nettype none
module srd_status_readback_command_decoder (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        scl,
  input  wire logic        sda_i,
  output var  logic        sda_o,
  output var  logic        sda_oe,
  input  wire logic        fuse_address_bit3,
  input  wire logic        fuse_address_bit2,
  input  wire logic        fuse_address_bit1,
  input  wire logic        fuse_address_bit0,
  input  wire logic        strap_address_bit,
  input  wire logic [63:0] fuse_bytes,
  input  wire logic [3:0]  run_current,
  input  wire logic [3:0]  hold_current,
  input  wire logic [3:0]  max_velocity,
  input  wire logic [3:0]  min_velocity,
  input  wire logic        ramp_profile,
  input  wire logic [1:0]  step_resolution,
  input  wire logic        shaft_direction,
  input  wire logic [3:0]  ramp_rate,
  input  wire logic        logic_supply_reset_flag,
  input  wire logic        missed_step_flag,
  input  wire logic        electrical_defect_flag,
  input  wire logic        undervoltage_flag,
  input  wire logic        thermal_shutdown,
  input  wire logic        thermal_warning,
  input  wire logic [1:0]  temperature_level,
  input  wire logic [2:0]  movement_state,
  input  wire logic        external_switch_state,
  input  wire logic        coil1_overcurrent,
  input  wire logic        coil2_overcurrent,
  input  wire logic        charge_pump_fault,
  input  wire logic [15:0] actual_position,
  input  wire logic [15:0] target_position,
  input  wire logic [10:0] safe_position,
  output var  logic        move_to_safe_position,
  output var  logic [7:0]  last_command
);

  // clk domain state
  typedef struct packed {
    logic        tgl_s1;
    logic        tgl_s2;
    logic        tgl_s3;
    logic        strap_s1;
    logic        strap_s2;
    logic [1:0]  strap_age;
    logic        strap;
    logic [6:0]  own_addr;
    logic [7:0]  last_command;
    logic        move;
    logic [63:0] reply;
  } srd_core_t;

  // link clock state, sampled on rising scl
  typedef struct packed {
    srd_pkg::srd_link_state_t st;
    logic [3:0]               bit_cnt;
    logic [6:0]               shift;
    logic                     gcall;
    logic                     ack_pend;
    logic [3:0]               tx_idx;
  } srd_link_t;

  // command hand-off from the link side, kept across frame clears
  typedef struct packed {
    logic [7:0] cmd;
    logic       cmd_tgl;
  } srd_hold_t;

  // pin drive state, updated on falling scl
  typedef struct packed {
    logic sda_o;
    logic sda_oe;
  } srd_drive_t;

  srd_core_t  cq;
  srd_core_t  next_cq;
  srd_link_t  lq;
  srd_link_t  next_lq;
  srd_hold_t  hq;
  srd_hold_t  next_hq;
  srd_drive_t dq;
  srd_drive_t next_dq;
  logic       link_clear;
  logic       link_rst_n;
  logic [7:0] rx_byte;
  logic [7:0] tx_byte;
  logic [3:0] fuse_addr;

  // masks the low position bits when half stepping
  function automatic logic [15:0] srd_pos_view(input logic [15:0] pos, input logic [1:0] res);
    srd_pos_view = (res == srd_pkg::SRD_STEP_HALF) ? (pos & srd_pkg::SRD_HALF_STEP_MASK) : pos; // [R10]
  endfunction

  srd_bus_watch u_watch (
    .clk        (clk),
    .resetn     (resetn),
    .scl_pin    (scl),
    .sda_pin    (sda_i),
    .link_clear (link_clear)
  );

  // link logic is held in reset outside frames, so no scl edge is relied on there
  assign link_rst_n = resetn & ~link_clear;
  assign fuse_addr  = {fuse_address_bit3, fuse_address_bit2, fuse_address_bit1, fuse_address_bit0};
  assign rx_byte    = {lq.shift, sda_i};
  assign tx_byte    = cq.reply[{lq.tx_idx[2:0], 3'h0} +: 8];

  // reply snapshot, command decode and strap capture in the clk domain
  always_comb begin
    next_cq          = cq;
    next_cq.tgl_s1   = hq.cmd_tgl;
    next_cq.tgl_s2   = cq.tgl_s1;
    next_cq.tgl_s3   = cq.tgl_s2;
    next_cq.strap_s1 = strap_address_bit;
    next_cq.strap_s2 = cq.strap_s1;
    next_cq.move     = 1'b0;
    // strap is a board level; taken once the synchroniser has filled, so a bounce cannot move it later
    if (cq.strap_age != 2'h3) begin
      next_cq.strap     = cq.strap_s2;
      next_cq.strap_age = cq.strap_age + 2'h1;
    end
    next_cq.own_addr = {srd_pkg::SRD_ADDR_FIXED, fuse_addr, cq.strap}; // [R16]
    // the command byte is stable in the link domain once its toggle has crossed
    if (cq.tgl_s2 != cq.tgl_s3) begin
      next_cq.last_command = hq.cmd;
      case (hq.cmd)
        srd_pkg::SRD_CMD_FULL_STATUS: begin // [R1] [R5]
          next_cq.reply = {srd_pkg::SRD_FILLER, srd_pkg::SRD_FILLER, // [R17]
                           movement_state, external_switch_state, coil1_overcurrent,
                           coil2_overcurrent, srd_pkg::SRD_STATUS3_FIXED, charge_pump_fault, // [R9]
                           logic_supply_reset_flag, missed_step_flag, electrical_defect_flag,
                           undervoltage_flag, thermal_shutdown, thermal_warning, temperature_level, // [R8]
                           ramp_profile, step_resolution, shaft_direction, ramp_rate, // [R7]
                           max_velocity, min_velocity, run_current, hold_current, // [R6]
                           srd_pkg::SRD_ECHO_FIXED, fuse_addr}; // [R17]
        end
        srd_pkg::SRD_CMD_POSITIONS: begin // [R2]
          next_cq.reply = {srd_pkg::SRD_FILLER, // [R13]
                           srd_pkg::SRD_SAFE_HI_FILL, safe_position[10:8], safe_position[7:0], // [R12] [R13]
                           srd_pos_view(target_position, step_resolution), // [R11] [R12]
                           srd_pos_view(actual_position, step_resolution), // [R11]
                           srd_pkg::SRD_ECHO_FIXED, fuse_addr}; // [R17]
          // byte order on the wire is high then low, so swap within each position
          next_cq.reply[23:8]  = {next_cq.reply[15:8], next_cq.reply[23:16]};
          next_cq.reply[39:24] = {next_cq.reply[31:24], next_cq.reply[39:32]};
        end
        srd_pkg::SRD_CMD_FUSE_BYTES: begin
          next_cq.reply = fuse_bytes; // [R3] [R14]
        end
        srd_pkg::SRD_CMD_MOVE_SAFE: begin
          next_cq.move = 1'b1; // [R4] [R15]
        end
        default: begin
          next_cq.reply = srd_pkg::SRD_REPLY_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cq <= '{tgl_s1: 1'b0, tgl_s2: 1'b0, tgl_s3: 1'b0, strap_s1: 1'b0, strap_s2: 1'b0,
              strap_age: 2'h0, strap: 1'b0, own_addr: 7'h00, last_command: 8'h00,
              move: 1'b0, reply: srd_pkg::SRD_REPLY_RESET};
    end else begin
      cq <= next_cq;
    end
  end

  // byte reception, address match and acknowledge decisions on rising scl
  always_comb begin
    next_lq = lq;
    next_hq = hq;
    if (lq.bit_cnt != srd_pkg::SRD_ACK_SLOT) begin
      next_lq.shift   = rx_byte[6:0];
      next_lq.bit_cnt = lq.bit_cnt + 4'h1;
    end else begin
      next_lq.bit_cnt = 4'h0;
    end
    if (lq.bit_cnt == srd_pkg::SRD_LAST_BIT) begin
      case (lq.st)
        srd_pkg::SRD_LS_ADDR: begin
          if (rx_byte[7:1] == cq.own_addr) begin // [R16]
            next_lq.ack_pend = 1'b1;
            next_lq.gcall    = 1'b0;
            next_lq.tx_idx   = 4'h0;
            next_lq.st       = (rx_byte[0] == srd_pkg::SRD_RW_READ) ? srd_pkg::SRD_LS_TX : srd_pkg::SRD_LS_CMD;
          end else if (rx_byte[7:1] == srd_pkg::SRD_GENERAL_CALL && rx_byte[0] != srd_pkg::SRD_RW_READ) begin
            next_lq.ack_pend = 1'b1; // [R15]
            next_lq.gcall    = 1'b1;
            next_lq.st       = srd_pkg::SRD_LS_CMD;
          end else begin
            next_lq.st = srd_pkg::SRD_LS_IGNORE;
          end
        end
        srd_pkg::SRD_LS_CMD: begin
          // under general call only the safe position move is taken
          if (!lq.gcall || rx_byte == srd_pkg::SRD_CMD_MOVE_SAFE) begin // [R15]
            next_hq.cmd      = rx_byte;
            next_hq.cmd_tgl  = ~hq.cmd_tgl;
            next_lq.ack_pend = 1'b1;
            next_lq.st       = srd_pkg::SRD_LS_DATA;
          end else begin
            next_lq.st = srd_pkg::SRD_LS_IGNORE;
          end
        end
        srd_pkg::SRD_LS_DATA: begin
          next_lq.ack_pend = 1'b1; // trailing parameter bytes are acknowledged and dropped
        end
        default: begin
          next_lq.ack_pend = 1'b0;
        end
      endcase
    end
    if (lq.bit_cnt == srd_pkg::SRD_ACK_SLOT) begin
      if (lq.ack_pend) begin
        next_lq.ack_pend = 1'b0;
      end else if (lq.st == srd_pkg::SRD_LS_TX) begin
        // a master nack ends the reply; the slave then stays off the line
        if (sda_i || lq.tx_idx == srd_pkg::SRD_TX_DONE) begin
          next_lq.st = srd_pkg::SRD_LS_IGNORE;
        end else begin
          next_lq.tx_idx = lq.tx_idx + 4'h1;
        end
      end
    end
  end

  // link state restarts with every frame
  always_ff @(posedge scl or negedge link_rst_n) begin
    if (!link_rst_n) begin
      lq <= '{st: srd_pkg::SRD_LS_ADDR, bit_cnt: 4'h0, shift: 7'h00, gcall: 1'b0, ack_pend: 1'b0, tx_idx: 4'h0};
    end else begin
      lq <= next_lq;
    end
  end

  // cmd and its toggle survive frame clears so the clk domain never sees a spurious edge
  always_ff @(posedge scl or negedge resetn) begin
    if (!resetn) begin
      hq <= '{cmd: 8'h00, cmd_tgl: 1'b0};
    end else begin
      hq <= next_hq;
    end
  end

  // open drain drive set up on falling scl, so sda only moves while scl is low
  always_comb begin
    next_dq        = dq;
    next_dq.sda_o  = 1'b0;
    next_dq.sda_oe = 1'b1;
    if (lq.ack_pend && lq.bit_cnt == srd_pkg::SRD_ACK_SLOT) begin
      next_dq.sda_oe = 1'b0;
    end else if (lq.st == srd_pkg::SRD_LS_TX && lq.bit_cnt != srd_pkg::SRD_ACK_SLOT &&
                 lq.tx_idx != srd_pkg::SRD_TX_DONE) begin
      next_dq.sda_oe = tx_byte[3'(srd_pkg::SRD_LAST_BIT - lq.bit_cnt)]; // [R5] [R14]
    end
  end

  always_ff @(negedge scl or negedge link_rst_n) begin
    if (!link_rst_n) begin
      dq <= '{sda_o: 1'b0, sda_oe: 1'b1};
    end else begin
      dq <= next_dq;
    end
  end

  assign sda_o                 = dq.sda_o;
  assign sda_oe                = dq.sda_oe;
  assign move_to_safe_position = cq.move;
  assign last_command          = cq.last_command;

endmodule
`default_nettype wire

/* File: tb/srd_bus_master.sv */
`default_nettype none
module srd_bus_master #(
  parameter int Q = 72
) (
  output var  logic scl,
  output var  logic sda_low,
  input  wire logic sda
);
  timeunit 1ns;
  timeprecision 1ns;

  // bus idle: both lines released to the pull-ups
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // start held long with scl high so the clk-side detector sees it
  task automatic start();
    sda_low = 1'b1;
    #(2*Q) scl = 1'b0;
  endtask

  // one slot: data moves mid-low, sampled mid-high, so setup and hold stay above 60 ns
  task automatic slot(input logic b, output logic s);
    #Q sda_low = ~b;
    #Q scl = 1'b1;
    #Q s = sda;
    #Q scl = 1'b0;
  endtask

  // stop ends every frame, so a read is always a transfer of its own
  task automatic stop();
    #Q sda_low = 1'b1;
    #Q scl = 1'b1;
    #(2*Q) sda_low = 1'b0;
    #(2*Q);
  endtask

  // byte out msb first, then the receiver's acknowledge slot
  task automatic put(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) slot(d[i], s);
    slot(1'b1, s);
    ack = ~s;
  endtask

  // byte in msb first; the last byte is not acknowledged
  task automatic get(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      slot(1'b1, s);
      d[i] = s;
    end
    slot(last, s);
  endtask
endmodule
`default_nettype wire

/* File: tb/srd_decoder_props.sv */
`default_nettype none
module srd_decoder_props (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       scl,
  input  wire logic       sda_i,
  input  wire logic       sda_o,
  input  wire logic       sda_oe,
  input  wire logic       move_to_safe_position,
  input  wire logic [7:0] last_command
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // move pulse stands for the safe move code only
  a_move_cmd_code: assert property (
    move_to_safe_position |-> last_command == srd_pkg::SRD_CMD_MOVE_SAFE)
    else $error("move pulse without safe move command");
  a_move_one_pulse: assert property (
    move_to_safe_position |=> !move_to_safe_position)
    else $error("move pulse longer than one cycle");
  a_move_not_other: assert property (
    $changed(last_command) && last_command != srd_pkg::SRD_CMD_MOVE_SAFE |-> !move_to_safe_position)
    else $error("move pulse on another command");
  a_move_in_high: assert property (
    move_to_safe_position |-> scl && sda_oe)
    else $error("move decoded outside the command bit");
  a_cmd_settle: assert property (
    $changed(last_command) |=> $stable(last_command)[*8])
    else $error("decoded command changed too fast");
  // the device only moves data while scl is low and never drives high
  a_oe_scl_low: assert property (
    $changed(sda_oe) |-> !scl)
    else $error("sda drive changed while scl high");
  a_sda_o_low: assert property (
    sda_o == 1'b0)
    else $error("sda output not open drain");
  a_oe_start_stop: assert property (
    scl && $past(scl) && $changed(sda_i) |-> sda_oe)
    else $error("device drove sda at start or stop");
endmodule

bind srd_status_readback_command_decoder srd_decoder_props i_props (
  .clk(clk), .resetn(resetn), .scl(scl), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
  .move_to_safe_position(move_to_safe_position), .last_command(last_command)
);
`default_nettype wire

/* File: tb/srd_status_readback_command_decoder_tb.sv */
`default_nettype none
module srd_status_readback_command_decoder_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, resetn, scl, sda_i, sda_o, sda_oe, m_low, move_to_safe_position, strap_address_bit;
  logic        fuse_address_bit3, fuse_address_bit2, fuse_address_bit1, fuse_address_bit0;
  logic        ramp_profile, shaft_direction, logic_supply_reset_flag, missed_step_flag, electrical_defect_flag;
  logic        undervoltage_flag, thermal_shutdown, thermal_warning, external_switch_state;
  logic        coil1_overcurrent, coil2_overcurrent, charge_pump_fault;
  logic [1:0]  step_resolution, temperature_level;
  logic [2:0]  movement_state;
  logic [3:0]  run_current, hold_current, max_velocity, min_velocity, ramp_rate;
  logic [7:0]  last_command;
  logic [10:0] safe_position;
  logic [15:0] actual_position, target_position;
  logic [63:0] fuse_bytes;
  int          bad_count, n_checks, n_move;

  srd_bus_master i_mst (.scl(scl), .sda_low(m_low), .sda(sda_i));
  // pulled-up wire: low when either party pulls it
  assign sda_i = (m_low || (sda_oe === 1'b0 && sda_o === 1'b0)) ? 1'b0 : 1'b1;

  srd_status_readback_command_decoder i_dut (
    .clk, .resetn, .scl, .sda_i, .sda_o, .sda_oe, .fuse_address_bit3, .fuse_address_bit2,
    .fuse_address_bit1, .fuse_address_bit0, .strap_address_bit, .fuse_bytes, .run_current,
    .hold_current, .max_velocity, .min_velocity, .ramp_profile, .step_resolution, .shaft_direction,
    .ramp_rate, .logic_supply_reset_flag, .missed_step_flag, .electrical_defect_flag,
    .undervoltage_flag, .thermal_shutdown, .thermal_warning, .temperature_level, .movement_state,
    .external_switch_state, .coil1_overcurrent, .coil2_overcurrent, .charge_pump_fault,
    .actual_position, .target_position, .safe_position, .move_to_safe_position, .last_command
  );

  always #5 clk = ~clk;

  // count move pulses seen on the clk side
  always @(posedge clk)
    if (move_to_safe_position === 1'b1) n_move <= n_move + 1;

  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    if (bad_count == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // write frame: address with write bit, then one command byte; gap lets the clk side decode
  task automatic send(input logic [7:0] adr, input logic [7:0] cmd, output logic [1:0] acks);
    @(negedge clk);
    i_mst.start();
    i_mst.put(adr, acks[1]);
    i_mst.put(cmd, acks[0]);
    i_mst.stop();
    #1000;
  endtask

  // read frame at the own address (strap 1, fuse address 1010): eight reply bytes
  task automatic fetch(output logic [63:0] r);
    logic a;
    @(negedge clk);
    i_mst.start();
    i_mst.put(8'heb, a);
    chk("read address ack", a, 1'b1);
    for (int k = 7; k >= 0; k--) i_mst.get(k == 0, r[8*k +: 8]);
    i_mst.stop();
    #1000;
  endtask

  initial begin
    logic [63:0] r;
    logic [1:0]  ak;
    logic        a;
    clk = 1'b0;
    resetn = 1'b0;
    {fuse_address_bit3, fuse_address_bit2, fuse_address_bit1, fuse_address_bit0, strap_address_bit} = 5'h15;
    fuse_bytes = 64'h8877_6655_4433_2211;
    {run_current, hold_current, max_velocity, min_velocity} = 16'h5a3c;
    {ramp_profile, step_resolution, shaft_direction, ramp_rate} = 8'hb6;
    {logic_supply_reset_flag, missed_step_flag, electrical_defect_flag, undervoltage_flag,
     thermal_shutdown, thermal_warning, temperature_level} = 8'ha6;
    {movement_state, external_switch_state, coil1_overcurrent, coil2_overcurrent, charge_pump_fault} = 7'h54;
    actual_position = 16'h1237;
    target_position = 16'habcf;
    safe_position = 11'h5a3;
    repeat (3) @(negedge clk);
    resetn = 1'b1;
    repeat (8) @(negedge clk);
    send(8'hea, 8'h81, ak);
    chk("status write acks", ak, 2'h3);
    chk("decoded command", last_command, 8'h81);
    fetch(r);
    chk("full status reply", r, 64'hfa5a_3cb6_a6aa_ffff);
    send(8'hea, 8'hfc, ak);
    fetch(r);
    chk("position reply", r, 64'hfa12_37ab_cfa3_fdff);
    @(negedge clk);
    step_resolution = 2'h0;
    send(8'hea, 8'hfc, ak);
    fetch(r);
    chk("half step positions", r, 64'hfa12_30ab_c8a3_fdff);
    send(8'hea, 8'h82, ak);
    fetch(r);
    chk("fuse reply", r, 64'h1122_3344_5566_7788);
    // safe move at own address and at general call; reply kept
    send(8'hea, 8'h84, ak);
    send(8'h00, 8'h84, ak);
    chk("general call acks", ak, 2'h3);
    chk("move pulses", n_move, 2);
    fetch(r);
    chk("reply after move", r, 64'h1122_3344_5566_7788);
    // refusals: other command at general call, wrong strap bit
    send(8'h00, 8'h81, ak);
    chk("general call other cmd", ak, 2'h2);
    send(8'he8, 8'h84, ak);
    chk("foreign address acks", ak, 2'h0);
    chk("command kept", last_command, 8'h84);
    chk("no further move", n_move, 2);
    // unknown command with a trailing byte
    @(negedge clk);
    i_mst.start();
    i_mst.put(8'hea, ak[1]);
    i_mst.put(8'h85, ak[0]);
    i_mst.put(8'h5a, a);
    i_mst.stop();
    #1000;
    chk("unknown command acks", {ak, a}, 3'h7);
    fetch(r);
    chk("unknown command reply", r, 64'hffff_ffff_ffff_ffff);
    end_of_test();
  end

  // watchdog well beyond the expected run length
  initial begin
    #500_000;
    bad_count++;
    end_of_test();
  end
endmodule
`default_nettype wire
